// File: bench/contact_model.sv
`timescale 1ns/100ps
module contact_model (
   input  wire       core_clk_i,
   input  wire [3:0] close_i,
   input  wire       press_i,
   output reg  [3:0] safety_o,
   output reg        button_o,
   output wire [3:0] sel_o
);
   // button wired to basic input five
   assign sel_o = 4'h5;
   initial begin
      safety_o = 4'h0;
      button_o = 1'h0;
   end
   always @(posedge core_clk_i) begin
      safety_o <= close_i;
      button_o <= press_i;
   end
endmodule

// File: bench/start_reset_monitor_asserts.sv
`timescale 1ns/100ps
`include "start_reset_defs.vh"
module srm_checker (
   input wire                  core_clk_i,
   input wire                  rst_i,
   input wire [`NUM_ELEMS-1:0] elem_enable_i,
   input wire [`NUM_ELEMS-1:0] safety_circuit_input_i,
   input wire                  fault_acknowledge_option_i,
   input wire [`NUM_FUNCS-1:0] func_trip_i,
   input wire [`NUM_ELEMS-1:0] released_o,
   input wire                  cross_short_enable_o,
   input wire                  ack_pulse_o,
   input wire                  logic_reset_o,
   input wire [`NUM_FUNCS-1:0] func_tripped_o,
   input wire                  unrecoverable_error_o,
   input wire                  cycle_tick_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_held; func_tripped_o[0] ##1 !ack_pulse_o; endsequence
   property p_drop; !safety_circuit_input_i[0] |-> !released_o[0]; endproperty
   property p_elem; !elem_enable_i[1] |-> !released_o[1]; endproperty
   property p_xs; fault_acknowledge_option_i |=> !cross_short_enable_o; endproperty
   property p_pulse; ack_pulse_o |=> !ack_pulse_o; endproperty
   property p_lr; logic_reset_o |=> !logic_reset_o; endproperty
   property p_cyc; ack_pulse_o |-> cycle_tick_o; endproperty
   property p_fatal; unrecoverable_error_o |=> unrecoverable_error_o; endproperty
   property p_latch; s_held |-> func_tripped_o[0]; endproperty
   property p_cam; func_trip_i[2] |=> func_tripped_o[2]; endproperty
   a_drop: assert property (p_drop) else $error("released with open circuit");
   a_elem: assert property (p_elem) else $error("unconnected element released");
   a_xs: assert property (p_xs) else $error("cross-short check left on");
   a_pulse: assert property (p_pulse) else $error("acknowledge pulse too long");
   a_lr: assert property (p_lr) else $error("logic reset pulse too long");
   a_cyc: assert property (p_cyc) else $error("pulse outside cycle tick");
   a_fatal: assert property (p_fatal) else $error("fatal error cleared");
   a_latch: assert property (p_latch) else $error("trip lost unacknowledged");
   a_cam: assert property (p_cam) else $error("cam trip not shown");
endmodule
bind start_reset_monitor srm_checker chk_i (.core_clk_i, .rst_i, .elem_enable_i,
   .safety_circuit_input_i, .fault_acknowledge_option_i, .func_trip_i, .released_o,
   .cross_short_enable_o, .ack_pulse_o, .logic_reset_o, .func_tripped_o,
   .unrecoverable_error_o, .cycle_tick_o);

// File: bench/start_reset_monitor_bench.sv
`timescale 1ns/100ps
module start_reset_monitor_bench;
   logic clk = 0, rst = 1, mode = 0, ackb = 0, fbtn = 0, alarm = 1, fatal = 1, prs = 0;
   logic [3:0]  en = 4'hF, cls = 4'h0;
   logic [10:0] trip = 11'h7FF;
   wire  [3:0]  saf, sel, rel;
   wire  [10:0] fto;
   wire         btn, xs, ap, lr, alo, ueo, tk, bsv;
   int          n_fail = 0, n_checks = 0, n;
   contact_model pm (.core_clk_i(clk), .close_i(cls), .press_i(prs), .safety_o(saf),
      .button_o(btn), .sel_o(sel));
   start_reset_monitor #(.CYCLE_CLKS_P(50)) dut (.core_clk_i(clk), .rst_i(rst), .start_mode_i(mode),
      .elem_enable_i(en), .safety_circuit_input_i(saf), .start_button_input_i(btn),
      .fault_acknowledge_option_i(1'h1), .logic_reset_option_i(1'h1), .ack_button_i(ackb),
      .function_button_i(fbtn), .func_trip_i(trip), .alarm_i(alarm),
      .unrecoverable_error_i(fatal), .button_input_sel_i(sel), .released_o(rel),
      .cross_short_enable_o(xs), .ack_pulse_o(ap), .logic_reset_o(lr), .func_tripped_o(fto),
      .alarm_o(alo), .unrecoverable_error_o(ueo), .button_sel_valid_o(bsv), .cycle_tick_o(tk));
   initial begin
      forever #10 clk = ~clk;
   end
   task chk(input string nm, input [15:0] got, input [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // set contacts, then run to the next controller cycle
   task step(input [3:0] s, input b, input a, input f);
      cls = s; prs = b; ackb = a; fbtn = f; n = 0;
      do begin
         @(posedge clk); #1 n++;
      end while (tk !== 1'b1 && n < 100);
      chk("tick", tk, 16'h1);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #100000 n_fail++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 rst = 0;
      @(posedge clk); #1 alarm = 0; fatal = 0; trip = 11'h0;
      step(4'hF, 0, 0, 0); chk("released", rel, 16'h0);
      chk("xshort", xs, 16'h0);
      chk("sel valid", bsv, 16'h1);
      chk("tripped", fto, 16'h4FB);
      chk("alarm", alo, 16'h1);
      step(4'hF, 1, 0, 0); chk("released", rel, 16'hF);
      cls = 4'hE; repeat (2) @(posedge clk);
      #1 chk("released", rel, 16'hE);
      step(4'hE, 0, 0, 0); cls = 4'hF; repeat (2) @(posedge clk);
      #1 chk("released", rel, 16'hE);
      $display("test manual done");
      step(4'hF, 0, 1, 0); chk("ack", ap, 16'h1);
      chk("logic reset", lr, 16'h1);
      chk("tripped", fto, 16'h0);
      chk("alarm", alo, 16'h0);
      chk("fatal", ueo, 16'h1);
      step(4'hF, 0, 1, 0); chk("ack", ap, 16'h0);
      step(4'hF, 0, 0, 0); step(4'hF, 0, 0, 1); chk("ack", ap, 16'h1);
      $display("test acknowledge done");
      mode = 1; en = 4'h7;
      step(4'h0, 0, 0, 0); step(4'hF, 1, 0, 0); chk("released", rel, 16'h0);
      step(4'hF, 0, 0, 0); chk("released", rel, 16'h7);
      $display("test monitored done");
      summarize();
   end
endmodule

// File: rtl/start_channel.v
`timescale 1ns/100ps
`include "start_reset_defs.vh"

module start_channel (
   input  wire core_clk_i,
   input  wire rst_i,
   input  wire tick_i,
   input  wire mode_i,
   input  wire safety_circuit_input_i,
   input  wire start_button_input_i,
   output wire released_o
);

   reg safety_state_marker_ff;
   reg start_latch_marker_ff;
   reg button_released_marker_ff;
   reg nxt_start_latch;
   reg nxt_button_released;

   always @* begin
      nxt_start_latch     = start_latch_marker_ff;
      nxt_button_released = button_released_marker_ff;
      if (safety_circuit_input_i && start_button_input_i) begin
         nxt_start_latch = 1'h1;
      end
      if (!safety_circuit_input_i) begin
         nxt_start_latch = 1'h0;
      end
      if (!safety_circuit_input_i && !start_button_input_i) begin
         nxt_button_released = 1'h1;
      end
      if (safety_circuit_input_i && nxt_start_latch && !start_button_input_i) begin
         nxt_button_released = 1'h1;
      end
      if (!safety_circuit_input_i && start_button_input_i) begin
         nxt_button_released = 1'h0;
      end
      if (safety_circuit_input_i && !start_latch_marker_ff && start_button_input_i) begin
         nxt_button_released = 1'h0;
      end
   end

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         safety_state_marker_ff    <= 1'h0;
         start_latch_marker_ff     <= 1'h0;
         button_released_marker_ff <= 1'h0;
      end else if (tick_i) begin
         safety_state_marker_ff    <= safety_circuit_input_i;
         start_latch_marker_ff     <= nxt_start_latch;
         button_released_marker_ff <= nxt_button_released;
      end
   end

   // safety loss drops the output at once, without waiting for the next tick
   assign released_o = safety_circuit_input_i && safety_state_marker_ff &&
                       start_latch_marker_ff &&
                       ((mode_i == `MODE_MANUAL) || button_released_marker_ff);

endmodule

// File: rtl/start_reset_defs.vh
`ifndef START_RESET_DEFS_VH
`define START_RESET_DEFS_VH

// controller cycle length in microseconds and the clock rate in kHz
`define CYCLE_TIME_US     8000
`define CORE_CLK_KHZ      50000
// cycles of core_clk_i per controller cycle (8 ms at 50 MHz)
`define CYCLE_CLKS        ((`CYCLE_TIME_US * `CORE_CLK_KHZ) / 1000)
`define CYCLE_CNT_W       19

// start modes
`define MODE_MANUAL       1'h0
`define MODE_MONITORED    1'h1

// number of monitored input elements and monitoring functions
`define NUM_ELEMS         4
`define NUM_FUNCS         11

// function bit positions in the trip vectors
`define FN_END_LIMIT      0
`define FN_LIMITED_POS    1
`define FN_CAM            2
`define FN_STOP_RAMP      3
`define FN_LIMITED_INC    4
`define FN_DIRECTION      5
`define FN_LIMITED_SPEED  6
`define FN_OPERATING_STOP 7
`define FN_ACCEL          8
`define FN_POS_DEVIATION  9
`define FN_ENCODER_COND   10

// functions whose trip latches until acknowledged; the others follow their trip input
`define ACK_REQUIRED_MASK 11'h4FB

`endif

// File: rtl/start_reset_monitor.v
`timescale 1ns/100ps
`include "start_reset_defs.vh"

module start_reset_monitor #(
   // clocks per controller cycle; the default gives 8 ms at 50 MHz
   parameter CYCLE_CLKS_P = `CYCLE_CLKS
) (
   input  wire                    core_clk_i,
   input  wire                    rst_i,
   input  wire                    start_mode_i,
   input  wire [`NUM_ELEMS-1:0]   elem_enable_i,
   input  wire [`NUM_ELEMS-1:0]   safety_circuit_input_i,
   input  wire                    start_button_input_i,
   input  wire                    fault_acknowledge_option_i,
   input  wire                    logic_reset_option_i,
   input  wire                    ack_button_i,
   input  wire                    function_button_i,
   input  wire [`NUM_FUNCS-1:0]   func_trip_i,
   input  wire                    alarm_i,
   input  wire                    unrecoverable_error_i,
   input  wire [3:0]              button_input_sel_i,
   output wire [`NUM_ELEMS-1:0]   released_o,
   output reg                     cross_short_enable_o,
   output reg                     ack_pulse_o,
   output reg                     logic_reset_o,
   output reg  [`NUM_FUNCS-1:0]   func_tripped_o,
   output reg                     alarm_o,
   output reg                     unrecoverable_error_o,
   output reg                     button_sel_valid_o,
   output reg                     cycle_tick_o
);

   localparam [31:0]             CYCLE_LAST_FULL = CYCLE_CLKS_P - 1;
   localparam [`CYCLE_CNT_W-1:0] CYCLE_LAST = CYCLE_LAST_FULL[`CYCLE_CNT_W-1:0];
   localparam [`NUM_FUNCS-1:0]   ACK_MASK   = `ACK_REQUIRED_MASK;

   reg [`CYCLE_CNT_W-1:0] cycle_cnt_ff;
   reg                    ack_sample_ff;
   reg                    ack_edge;
   reg [`NUM_FUNCS-1:0]   nxt_tripped;
   reg                    nxt_alarm;
   wire                   tick;
   wire                   ack_level;

   // controller cycle divider
   assign tick = (cycle_cnt_ff == CYCLE_LAST);

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cycle_cnt_ff <= {`CYCLE_CNT_W{1'b0}};
         cycle_tick_o <= 1'h0;
      end else begin
         cycle_cnt_ff <= tick ? {`CYCLE_CNT_W{1'b0}} : cycle_cnt_ff + 1'b1;
         cycle_tick_o <= tick;
      end
   end

   // per-element start supervision
   genvar g;
   generate
      for (g = 0; g < `NUM_ELEMS; g = g + 1) begin : g_elem
         wire rel;
         start_channel u_chan (
            .core_clk_i             (core_clk_i),
            .rst_i                  (rst_i),
            .tick_i                 (tick),
            .mode_i                 (start_mode_i),
            .safety_circuit_input_i (safety_circuit_input_i[g]),
            .start_button_input_i   (start_button_input_i),
            .released_o             (rel)
         );
         assign released_o[g] = elem_enable_i[g] & rel;
      end
   endgenerate

   // acknowledge source: input or function button
   assign ack_level = ack_button_i | function_button_i;

   always @* begin
      ack_edge    = tick && ack_level && !ack_sample_ff;
      nxt_tripped = (func_tripped_o & ACK_MASK) | func_trip_i;
      nxt_alarm   = alarm_o | alarm_i;
      if (ack_edge && fault_acknowledge_option_i) begin
         // active trips reassert: set wins over clear
         nxt_tripped = func_trip_i;
         nxt_alarm   = alarm_i;
      end
   end

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_sample_ff         <= 1'h0;
         ack_pulse_o           <= 1'h0;
         logic_reset_o         <= 1'h0;
         func_tripped_o        <= {`NUM_FUNCS{1'b0}};
         alarm_o               <= 1'h0;
         unrecoverable_error_o <= 1'h0;
         cross_short_enable_o  <= 1'h0;
         button_sel_valid_o    <= 1'h0;
      end else begin
         if (tick) begin
            ack_sample_ff <= ack_level;
         end
         ack_pulse_o    <= ack_edge && fault_acknowledge_option_i;
         logic_reset_o  <= ack_edge && logic_reset_option_i;
         func_tripped_o <= nxt_tripped;
         alarm_o        <= nxt_alarm;
         // only a reset clears this flag
         unrecoverable_error_o <= unrecoverable_error_o | unrecoverable_error_i;
         cross_short_enable_o  <= !fault_acknowledge_option_i;
         button_sel_valid_o    <= (button_input_sel_i >= 4'h1) &&
                                  (button_input_sel_i <= 4'hE);
      end
   end

endmodule
